//--- rtl/slow_clock_defs.svh
// constants for the slow clock source and startup sequencer
// assumes a 100 MHz system clock and register indices scaled by four
`ifndef SLOW_CLOCK_DEFS_SVH
`define SLOW_CLOCK_DEFS_SVH

// ***********************
// register map (byte addresses)
// ***********************
`define ADDR_OSC_CONTROL   8'h00
`define ADDR_SLEEP_PERIOD  8'h04
`define ADDR_SLEEP_CLEAR   8'h08
`define ADDR_STATUS        8'h0c
`define ADDR_SLEEP_COUNT   8'h10

// ***********************
// field positions and reset values
// ***********************
`define CTRL_SOURCE_BIT    0
`define CTRL_PLL_BIT       1
`define CTRL_SPEED_LSB     2
`define CTRL_SPEED_MSB     3
`define CTRL_RESET         4'h0
`define STAT_ON_CRYSTAL    0
`define STAT_TERMINAL      1
`define STAT_SETTLING      2
`define SLEEP_PERIOD_RESET 16'h7fff

// ***********************
// timing
// ***********************
`define CLOCK_PERIOD_NS    10
`define LOCK_SETTLE_NS     16000000
`define LOCK_SETTLE_CYCLES ((`LOCK_SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define ONE_HZ_DIV_BITS    15

`endif

//--- rtl/slow_clock_pkg.sv
// types for the slow clock source and startup sequencer
// assumes slow_clock_defs.svh for the numeric constants
package slow_clock_pkg;

   typedef enum logic [1:0] {
      speed_3mhz,
      speed_6mhz,
      speed_12mhz,
      speed_24mhz
   } cpu_speed_t;

   typedef struct packed {
      cpu_speed_t cpu_speed;
      logic       pll_mode;
      logic       source_select;
   } osc_control_t;

endpackage

//--- rtl/pin_sync.sv
// two-stage synchroniser with rising-edge pulse
// assumes the input is asynchronous to clock
`timescale 1ns/100ps

module pin_sync (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // pin side
   input  wire logic async_in,
   // core side
   output logic      level,
   output logic      rise
);

   logic stage_one;
   logic stage_two;
   logic stage_three;

   // ***********************
   // sampling
   // ***********************
   // only stage_two reads stage_one
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stage_one   <= 1'b0;
         stage_two   <= 1'b0;
         stage_three <= 1'b0;
      end else begin
         stage_one   <= async_in;
         stage_two   <= stage_one;
         stage_three <= stage_two;
      end
   end

   assign level = stage_two;
   assign rise  = stage_two & ~stage_three;

endmodule

//--- rtl/slow_clock_control.sv
// slow clock source selection, sleep timer switchover and pll startup throttle
// assumes the two oscillators arrive as pins much slower than the 100 MHz clock
`timescale 1ns/100ps
`include "slow_clock_defs.svh"

module slow_clock_control #(
   parameter int unsigned SLEEP_WIDTH  = 16,
   parameter int unsigned SETTLE_COUNT = `LOCK_SETTLE_CYCLES,
   parameter int unsigned DIV_BITS     = `ONE_HZ_DIV_BITS
) (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   // register port
   input  wire logic [7:0]               addr,
   input  wire logic [31:0]              wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [31:0]              rdata,
   // oscillator pins and supply sense
   input  wire logic                     low_accuracy_internal_osc,
   input  wire logic                     external_crystal_osc,
   input  wire logic                     supply_is_3v,
   // clock tree and main oscillator control
   output logic                          crystal_enable,
   output logic                          crystal_pins_drive_oe,
   output logic                          slow_clock_tree,
   output logic                          one_hz_tick,
   output logic                          pll_enable,
   output slow_clock_pkg::cpu_speed_t    cpu_speed
);
   import slow_clock_pkg::*;

   localparam int unsigned SETTLE_BITS = $clog2(SETTLE_COUNT + 1);
   localparam logic [SETTLE_BITS-1:0] SETTLE_LAST = SETTLE_BITS'(SETTLE_COUNT - 1);

   function automatic cpu_speed_t slower(input cpu_speed_t a, input cpu_speed_t b);
      slower = (a < b) ? a : b;
   endfunction

   logic ilo_level, ilo_rise, eco_level, low_supply;
   pin_sync u_ilo (.clock(clock), .rst_b(rst_b), .async_in(low_accuracy_internal_osc),
                   .level(ilo_level), .rise(ilo_rise));
   pin_sync u_eco (.clock(clock), .rst_b(rst_b), .async_in(external_crystal_osc),
                   .level(eco_level), .rise());
   pin_sync u_sup (.clock(clock), .rst_b(rst_b), .async_in(supply_is_3v),
                   .level(low_supply), .rise());

   // ***********************
   // registers
   // ***********************
   osc_control_t           osc_control_reg_zero, next_osc_control;
   logic [SLEEP_WIDTH-1:0] sleep_period, next_sleep_period;
   logic [SLEEP_WIDTH-1:0] sleep_count, next_sleep_count;
   logic                   terminal_seen, next_terminal_seen;
   logic [31:0]            next_rdata;
   logic                   on_crystal, next_on_crystal;
   logic                   terminal_seen_enabled, next_terminal_seen_enabled;
   logic                   settling, next_settling;

   logic sleep_terminal;
   assign sleep_terminal = ilo_rise && (sleep_count == sleep_period);

   always_comb begin
      next_osc_control   = osc_control_reg_zero;
      next_sleep_period  = sleep_period;
      next_sleep_count   = sleep_count;
      next_terminal_seen = terminal_seen;
      next_rdata         = 32'h0;
      // timer ticks on the internal oscillator, so one second is only 0.5 to 2 s
      if (ilo_rise)
         next_sleep_count = sleep_terminal ? '0 : sleep_count + 1'b1;
      if (wr) begin
         unique case (addr)
            `ADDR_OSC_CONTROL: next_osc_control = osc_control_t'(wdata[`CTRL_SPEED_MSB:0]);
            `ADDR_SLEEP_PERIOD: next_sleep_period = wdata[SLEEP_WIDTH-1:0];
            `ADDR_SLEEP_CLEAR: begin
               next_sleep_count   = '0;
               next_terminal_seen = 1'b0;
            end
            default: ;
         endcase
      end
      // a terminal count in the clearing cycle still counts
      if (sleep_terminal)
         next_terminal_seen = 1'b1;
      if (rd) begin
         unique case (addr)
            `ADDR_OSC_CONTROL: next_rdata[`CTRL_SPEED_MSB:0] = osc_control_reg_zero;
            `ADDR_SLEEP_PERIOD: next_rdata[SLEEP_WIDTH-1:0] = sleep_period;
            `ADDR_STATUS: begin
               next_rdata[`STAT_ON_CRYSTAL] = on_crystal;
               next_rdata[`STAT_TERMINAL]   = terminal_seen;
               next_rdata[`STAT_SETTLING]   = settling;
            end
            `ADDR_SLEEP_COUNT: next_rdata[SLEEP_WIDTH-1:0] = sleep_count;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         osc_control_reg_zero <= osc_control_t'(`CTRL_RESET);
         sleep_period         <= SLEEP_WIDTH'(`SLEEP_PERIOD_RESET);
         sleep_count          <= '0;
         terminal_seen        <= 1'b0;
         rdata                <= 32'h0;
      end else begin
         osc_control_reg_zero <= next_osc_control;
         sleep_period         <= next_sleep_period;
         sleep_count          <= next_sleep_count;
         terminal_seen        <= next_terminal_seen;
         rdata                <= next_rdata;
      end
   end

   // ***********************
   // slow clock tree source
   // ***********************
   logic want_crystal, safe_point;
   logic next_tree, next_crystal_enable;
   logic [DIV_BITS-1:0] div_count, next_div_count;
   logic next_one_hz, tree_rise;

   // crystal only after a terminal count seen while it was enabled
   assign want_crystal = osc_control_reg_zero.source_select && terminal_seen_enabled;
   // swap only while tree and both sources are low, so no phase is cut short
   assign safe_point   = !slow_clock_tree && !ilo_level && !eco_level;
   assign tree_rise    = next_tree && !slow_clock_tree;

   always_comb begin
      next_crystal_enable        = osc_control_reg_zero.source_select;
      next_terminal_seen_enabled = terminal_seen_enabled;
      if (!osc_control_reg_zero.source_select)
         next_terminal_seen_enabled = 1'b0;
      else if (sleep_terminal)
         next_terminal_seen_enabled = 1'b1;
      next_on_crystal = on_crystal;
      if (safe_point)
         next_on_crystal = want_crystal;
      next_tree   = next_on_crystal ? eco_level : ilo_level;
      next_one_hz = 1'b0;
      next_div_count = div_count;
      if (tree_rise) begin
         next_div_count = div_count + 1'b1;
         next_one_hz    = &div_count;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         crystal_enable        <= 1'b0;
         crystal_pins_drive_oe <= 1'b0;
         terminal_seen_enabled <= 1'b0;
         on_crystal            <= 1'b0;
         slow_clock_tree       <= 1'b0;
         div_count             <= '0;
         one_hz_tick           <= 1'b0;
      end else begin
         crystal_enable        <= next_crystal_enable;
         crystal_pins_drive_oe <= 1'b0; // pins never driven by logic
         terminal_seen_enabled <= next_terminal_seen_enabled;
         on_crystal            <= next_on_crystal;
         slow_clock_tree       <= next_tree;
         div_count             <= next_div_count;
         one_hz_tick           <= next_one_hz;
      end
   end

   // ***********************
   // pll lock and cpu throttle
   // ***********************
   logic [SETTLE_BITS-1:0] settle_count, next_settle_count;
   logic        next_pll_enable;
   cpu_speed_t  next_cpu_speed, ceiling;

   always_comb begin
      // internal oscillator has no path to the lock input, so pll waits for crystal
      next_pll_enable   = osc_control_reg_zero.pll_mode && on_crystal;
      next_settling     = settling;
      next_settle_count = settle_count;
      if (next_pll_enable && !pll_enable) begin
         next_settling     = 1'b1;
         next_settle_count = '0;
      end else if (settling) begin
         next_settle_count = settle_count + 1'b1;
         if (settle_count == SETTLE_LAST)
            next_settling = 1'b0;
      end
      ceiling = low_supply ? speed_12mhz : speed_24mhz;
      // overshoot during lock: hold 3 MHz whatever software asks
      if (next_settling)
         ceiling = speed_3mhz;
      next_cpu_speed = slower(osc_control_reg_zero.cpu_speed, ceiling);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pll_enable   <= 1'b0;
         settling     <= 1'b0;
         settle_count <= '0;
         cpu_speed    <= speed_3mhz;
      end else begin
         pll_enable   <= next_pll_enable;
         settling     <= next_settling;
         settle_count <= next_settle_count;
         cpu_speed    <= next_cpu_speed;
      end
   end

endmodule

//--- test/osc_model.sv
// oscillator pins seen by the slow clock block
// assumes the enables come straight from the block
`timescale 1ns/100ps

// ****
// model
// ****
module osc_model #(
   parameter int ILO_HALF_NS  = 100,
   parameter int XTAL_HALF_NS = 150
) (
   // enables
   input  wire logic crystal_enable,
   input  wire logic crystal_pins_drive_oe,
   // oscillators
   output logic      low_accuracy_internal_osc,
   output logic      external_crystal_osc
);
   // supply bypass pin lies outside this block; the model keeps the supply ideal
   // inaccurate source, so the bench allows wide margins
   initial begin
      low_accuracy_internal_osc = 1'b0;
      forever #(ILO_HALF_NS) low_accuracy_internal_osc = ~low_accuracy_internal_osc;
   end
   // stops only at a phase end; a driven pin free-runs too fast
   initial begin
      external_crystal_osc = 1'b0;
      forever #(crystal_pins_drive_oe ? XTAL_HALF_NS / 3 : XTAL_HALF_NS)
         external_crystal_osc = crystal_enable & ~external_crystal_osc;
   end
endmodule

//--- test/slow_clock_checker.sv
// assertions on the slow clock block ports
// assumes the bind below reaches every instance
`timescale 1ns/100ps

// ****
// checker
// ****
module slow_clock_checker
   import slow_clock_pkg::*;
#(
   parameter int unsigned SETTLE_COUNT = 20
) (
   // clock and reset
   input wire logic                       clock,
   input wire logic                       rst_b,
   // watched ports
   input wire logic                       low_accuracy_internal_osc,
   input wire logic                       supply_is_3v,
   input wire logic                       crystal_enable,
   input wire logic                       crystal_pins_drive_oe,
   input wire logic                       slow_clock_tree,
   input wire logic                       one_hz_tick,
   input wire logic                       pll_enable,
   input wire slow_clock_pkg::cpu_speed_t cpu_speed
);
   logic [31:0] lock_cycles;
   logic [7:0]  idle_cycles;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clock) begin
      if (!rst_b || !pll_enable) lock_cycles <= 32'h0;
      else if (lock_cycles != 32'hffffffff) lock_cycles <= lock_cycles + 32'h1;
   end
   // long idle, so a pending return to the internal source is over
   always_ff @(posedge clock) begin
      if (!rst_b || crystal_enable) idle_cycles <= 8'h0;
      else if (idle_cycles != 8'hff) idle_cycles <= idle_cycles + 8'h1;
   end
   pins_hiz_a: assert property (!crystal_pins_drive_oe)
      else $error("crystal pins driven");
   pll_guard_a: assert property (pll_enable |-> crystal_enable)
      else $error("pll on without crystal");
   lock_start_a: assert property ($rose(pll_enable) |-> cpu_speed == speed_3mhz)
      else $error("cpu fast at pll start");
   lock_hold_a: assert property (pll_enable && lock_cycles < SETTLE_COUNT |-> cpu_speed == speed_3mhz)
      else $error("cpu fast while settling");
   supply_cap_a: assert property (supply_is_3v [*6] |-> cpu_speed != speed_24mhz)
      else $error("cpu over low supply ceiling");
   tree_source_a: assert property ((idle_cycles > 8'h40 && $stable(low_accuracy_internal_osc)) [*6]
      |-> slow_clock_tree == low_accuracy_internal_osc) else $error("tree not on internal source");
   tree_phase_a: assert property ($changed(slow_clock_tree) |-> $past(slow_clock_tree, 2) == $past(slow_clock_tree))
      else $error("short tree phase");
   tick_pulse_a: assert property (one_hz_tick |=> !one_hz_tick)
      else $error("tick longer than a cycle");
endmodule

bind slow_clock_control slow_clock_checker #(.SETTLE_COUNT(SETTLE_COUNT)) slow_clock_checker_inst (.clock, .rst_b,
   .low_accuracy_internal_osc, .supply_is_3v, .crystal_enable, .crystal_pins_drive_oe, .slow_clock_tree,
   .one_hz_tick, .pll_enable, .cpu_speed);

//--- test/tb.sv
// testbench for the slow clock block
// assumes osc_model and the checker are compiled first
`timescale 1ns/100ps
`include "slow_clock_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end

// ****
// bench
// ****
module tb;
   import slow_clock_pkg::*;
   localparam int unsigned SETTLE = 20;
   localparam int unsigned DIV    = 4;
   logic        tree_seen = 1'b0;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        supply_is_3v = 1'b0;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, v;
   logic        low_accuracy_internal_osc, external_crystal_osc, crystal_enable, crystal_pins_drive_oe;
   logic        slow_clock_tree, one_hz_tick, pll_enable;
   cpu_speed_t  cpu_speed;
   int          miscompares = 0, n_compared = 0, cycles = 0, polls, rises = 0, ticks = 0;

   slow_clock_control #(.SETTLE_COUNT(SETTLE), .DIV_BITS(DIV)) slow_clock_control_inst (.clock, .rst_b, .addr,
      .wdata, .wr, .rd, .rdata, .low_accuracy_internal_osc, .external_crystal_osc, .supply_is_3v, .crystal_enable,
      .crystal_pins_drive_oe, .slow_clock_tree, .one_hz_tick, .pll_enable, .cpu_speed);
   osc_model osc_model_inst (.crystal_enable, .crystal_pins_drive_oe, .low_accuracy_internal_osc,
      .external_crystal_osc);

   always #5 clock = ~clock;
   // every tree rise and tick, so the divider ratio can be checked at the end
   always @(posedge clock) begin
      tree_seen <= slow_clock_tree;
      if (rst_b && slow_clock_tree && !tree_seen) rises++;
      if (rst_b && one_hz_tick) ticks++;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles >= 20000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd_reg(a, d);
      `CHK($sformatf("reg %h", a), e, d)
   endtask

   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      // reset values, read-only and unmapped places
      rd_chk(`ADDR_OSC_CONTROL, 32'h0);
      rd_chk(`ADDR_SLEEP_PERIOD, 32'h7fff);
      wr_reg(`ADDR_STATUS, 32'hffffffff);
      rd_chk(`ADDR_STATUS, 32'h0);
      rd_chk(8'h14, 32'h0);
      // pll refused while the internal source drives the tree
      wr_reg(`ADDR_OSC_CONTROL, 32'h2);
      repeat (8) @(posedge clock);
      #1 `CHK("pll_enable", 1'b0, pll_enable)
      `CHK("crystal_enable", 1'b0, crystal_enable)
      // crystal start and timed switchover
      wr_reg(`ADDR_SLEEP_PERIOD, 32'h3);
      rd_chk(`ADDR_SLEEP_PERIOD, 32'h3);
      wr_reg(`ADDR_SLEEP_CLEAR, 32'h0);
      wr_reg(`ADDR_OSC_CONTROL, 32'h1);
      rd_chk(`ADDR_STATUS, 32'h0);
      `CHK("crystal_enable", 1'b1, crystal_enable)
      polls = 0;
      do begin
         rd_reg(`ADDR_STATUS, v);
         polls++;
      end while (v[0] !== 1'b1 && polls < 200);
      `CHK("switch delay", 1'b1, polls >= 20 && polls <= 150)
      `CHK("status", 32'h3, v)
      rd_reg(`ADDR_SLEEP_COUNT, v);
      `CHK("sleep count", 1'b1, v <= 32'h3)
      // pll start throttled, then the requested speed under the supply ceiling
      wr_reg(`ADDR_OSC_CONTROL, 32'hf);
      polls = 0;
      #1 while (pll_enable !== 1'b1 && polls < 8) begin
         @(posedge clock);
         #1 polls++;
      end
      `CHK("cpu_speed", speed_3mhz, cpu_speed)
      rd_chk(`ADDR_STATUS, 32'h7);
      repeat (SETTLE + 4) @(posedge clock);
      #1 `CHK("cpu_speed", speed_24mhz, cpu_speed)
      @(posedge clock);
      supply_is_3v <= 1'b1;
      repeat (8) @(posedge clock);
      #1 `CHK("cpu_speed", speed_12mhz, cpu_speed)
      wr_reg(`ADDR_OSC_CONTROL, 32'h7);
      repeat (2) @(posedge clock);
      #1 `CHK("cpu_speed", speed_6mhz, cpu_speed)
      rd_chk(`ADDR_OSC_CONTROL, 32'h7);
      // back to the internal source
      wr_reg(`ADDR_OSC_CONTROL, 32'h0);
      repeat (100) @(posedge clock);
      #1 `CHK("pll_enable", 1'b0, pll_enable)
      rd_chk(`ADDR_STATUS, 32'h2);
      `CHK("pins_oe", 1'b0, crystal_pins_drive_oe)
      repeat (400) @(posedge clock);
      #1 `CHK("tick seen", 1'b1, ticks > 0)
      `CHK("tick count", rises >> DIV, ticks)
      stop_test();
   end
endmodule
